// ---- design/multi_port_parallel_io.v ----
// Behaviour
// - Direction bit 0 makes the pin an input, 1 an output.
// - An enabled special function owns the pin, overriding direction.
// - Data writes go to latches; latches drive only general outputs.
// - Reading a general pin returns the real pin level.
// - Port C in wired-OR output mode reads the driver levels; port D reads pins.
// - Reset makes ports inputs; expanded mode excepts B, C, F, G7, G5:0.
// - Output enabled before a data write drives the reset latch value.
// - Port A eight bidirectional lines shared with timer functions.
// - Port B general pins single-chip; high address 15:8 when expanded.
// - Port C carries data 7:0 expanded; visibility drives internal reads.
// - Port C open-drain: zero pulls low, one floats.
// - Single-chip visibility bit holds E low; else E clock drives.
// - Visibility bit resets to zero and takes one write only.
// - Port E eight input-only pins, no direction, converter inputs.
// - Port F general pins single-chip; low address 7:0 when expanded.
// - Port G pin 7 general single-chip; read/write line expanded.
// - Port G 6:0 reset as inputs; 5:0 expansion address expanded.
// - Ports B, F, G have per-port switchable pullups.
// - Pullup settings act only when the assignment enable is set.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "multi_port_parallel_io_defs.vh"
module multi_port_parallel_io (
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire [8:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    input  wire        expanded_mode_i,
    input  wire        eclk_i,
    output wire        eclk_pin_o,
    input  wire [15:0] ext_addr_i,
    input  wire        ext_rw_i,
    input  wire [7:0]  ext_data_out_i,
    input  wire        ext_data_drive_i,
    input  wire        int_read_i,
    input  wire [7:0]  int_read_data_i,
    input  wire [5:0]  exp_addr_i,
    input  wire [7:0]  timer_en_i,
    input  wire [7:0]  timer_out_i,
    input  wire [7:0]  timer_oe_i,
    input  wire [5:0]  serial_en_i,
    input  wire [5:0]  serial_out_i,
    input  wire [5:0]  serial_oe_i,
    input  wire [7:0]  port_a_in_i,
    output wire [7:0]  port_a_out_o,
    output wire [7:0]  port_a_oe_n_o,
    input  wire [7:0]  port_b_in_i,
    output wire [7:0]  port_b_out_o,
    output wire [7:0]  port_b_oe_n_o,
    input  wire [7:0]  port_c_in_i,
    output wire [7:0]  port_c_out_o,
    output wire [7:0]  port_c_oe_n_o,
    output wire [7:0]  port_c_data_o,
    input  wire [5:0]  port_d_in_i,
    output wire [5:0]  port_d_out_o,
    output wire [5:0]  port_d_oe_n_o,
    input  wire [7:0]  port_e_in_i,
    input  wire [7:0]  port_f_in_i,
    output wire [7:0]  port_f_out_o,
    output wire [7:0]  port_f_oe_n_o,
    input  wire [7:0]  port_g_in_i,
    output wire [7:0]  port_g_out_o,
    output wire [7:0]  port_g_oe_n_o,
    output wire [2:0]  pullup_en_o
);

    reg  [7:0] dir_a_r, dir_b_r, dir_c_r, dir_d_r, dir_f_r, dir_g_r;
    reg  [7:0] lat_a_r, lat_b_r, lat_c_r, lat_d_r, lat_f_r, lat_g_r;
    reg        c_open_drain_r;
    reg        read_vis_r;
    reg        read_vis_done_r;
    reg  [2:0] pullup_r;
    reg        pullup_en_r;
    reg        ack_r;
    reg  [7:0] sa1_r, sa2_r, sb1_r, sb2_r, sc1_r, sc2_r;
    reg  [5:0] sd1_r, sd2_r;
    reg  [7:0] se1_r, se2_r, sf1_r, sf2_r, sg1_r, sg2_r;
    wire [6:0] idx = avs_address_i[8:2];
    wire       wr = avs_write_i & avs_byteenable_i[0];
    wire       exp = expanded_mode_i;
    reg  [7:0] rdata;

    // One wait state on every access keeps read data registered.
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;

    // Pins are asynchronous; two flops before any logic reads them.
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sa1_r <= 8'h00; sa2_r <= 8'h00; sb1_r <= 8'h00; sb2_r <= 8'h00;
            sc1_r <= 8'h00; sc2_r <= 8'h00; sd1_r <= 6'h00; sd2_r <= 6'h00;
            se1_r <= 8'h00; se2_r <= 8'h00; sf1_r <= 8'h00; sf2_r <= 8'h00;
            sg1_r <= 8'h00; sg2_r <= 8'h00;
        end else begin
            sa1_r <= port_a_in_i; sa2_r <= sa1_r;
            sb1_r <= port_b_in_i; sb2_r <= sb1_r;
            sc1_r <= port_c_in_i; sc2_r <= sc1_r;
            sd1_r <= port_d_in_i; sd2_r <= sd1_r;
            se1_r <= port_e_in_i; se2_r <= se1_r;
            sf1_r <= port_f_in_i; sf2_r <= sf1_r;
            sg1_r <= port_g_in_i; sg2_r <= sg1_r;
        end
    end

    // function override
    // Generic pin mix: special function first, else latch by direction.
    function [15:0] pin_mix;
        input [7:0] sf_en, sf_out, sf_oe, lat, dir;
        begin
            pin_mix = {(sf_en & sf_out) | (~sf_en & lat),
                       ~((sf_en & sf_oe) | (~sf_en & dir))};
        end
    endfunction

    // Read back: pin level, except open-drain outputs show driver level.
    function [7:0] read_mix;
        input [7:0] pin, lat, dir;
        input       od;
        begin
            read_mix = od ? ((dir & lat) | (~dir & pin)) : pin;
        end
    endfunction

    wire [15:0] mix_a = pin_mix(timer_en_i, timer_out_i, timer_oe_i,
                                lat_a_r, dir_a_r);
    wire [15:0] mix_b = pin_mix({8{exp}}, ext_addr_i[15:8], 8'hff,
                                lat_b_r, dir_b_r);
    wire [15:0] mix_f = pin_mix({8{exp}}, ext_addr_i[7:0], 8'hff,
                                lat_f_r, dir_f_r);
    wire [15:0] mix_g = pin_mix({exp, 1'b0, {6{exp}}},
                                {ext_rw_i, 1'b0, exp_addr_i},
                                {exp, 1'b0, {6{exp}}}, lat_g_r, dir_g_r);
    wire [15:0] mix_d = pin_mix({2'b00, serial_en_i},
                                {2'b00, serial_out_i},
                                {2'b00, serial_oe_i}, lat_d_r, dir_d_r);

    assign port_a_out_o  = mix_a[15:8];
    assign port_a_oe_n_o = mix_a[7:0];
    assign port_b_out_o  = mix_b[15:8];
    assign port_b_oe_n_o = mix_b[7:0];
    assign port_f_out_o  = mix_f[15:8];
    assign port_f_oe_n_o = mix_f[7:0];
    assign port_g_out_o  = mix_g[15:8];
    assign port_g_oe_n_o = mix_g[7:0];
    assign port_d_out_o  = mix_d[13:8];
    assign port_d_oe_n_o = mix_d[5:0];

    wire       c_bus = exp & (ext_data_drive_i | (read_vis_r & int_read_i));
    wire [7:0] c_bus_data = ext_data_drive_i ? ext_data_out_i
                                             : int_read_data_i;
    wire       c_od = c_open_drain_r & ~exp;
    assign port_c_out_o  = exp ? c_bus_data : (c_od ? 8'h00 : lat_c_r);
    assign port_c_oe_n_o = exp ? {8{~c_bus}}
                         : ~(dir_c_r & (c_od ? ~lat_c_r : 8'hff));
    assign port_c_data_o = sc2_r;

    assign eclk_pin_o = (read_vis_r & ~exp) ? 1'b0 : eclk_i;

    assign pullup_en_o = pullup_en_r ? pullup_r : 3'b000;

    always @* begin
        rdata = 8'h00;
        case (idx)
            `REG_PORT_A_DATA:      rdata = sa2_r;
            `REG_PORT_B_DATA:      rdata = sb2_r;
            `REG_PORT_C_DATA:      rdata = read_mix(sc2_r, lat_c_r,
                                                    dir_c_r, c_od);
            // Port D wired-OR belongs to the serial block; plain pins here.
            `REG_PORT_D_DATA:      rdata = {2'b00, sd2_r};
            `REG_PORT_E_DATA:      rdata = se2_r;
            `REG_PORT_F_DATA:      rdata = sf2_r;
            `REG_PORT_G_DATA:      rdata = sg2_r;
            `REG_PORT_A_DIRECTION: rdata = dir_a_r;
            `REG_PORT_B_DIRECTION: rdata = dir_b_r;
            `REG_PORT_C_DIRECTION: rdata = dir_c_r;
            `REG_PORT_D_DIRECTION: rdata = dir_d_r & `PORT_D_MASK;
            `REG_PORT_F_DIRECTION: rdata = dir_f_r;
            `REG_PORT_G_DIRECTION: rdata = dir_g_r;
            `REG_SYSTEM_OPTIONS_TWO: begin
                rdata[`SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN] = c_open_drain_r;
                rdata[`SYSTEM_OPTIONS_TWO_READ_VIS_ECLK_OFF] = read_vis_r;
            end
            `REG_PULLUP_ASSIGNMENT: rdata = {5'h00, pullup_r};
            `REG_SYSTEM_CONFIG:
                rdata[`CFG_PULLUP_ASSIGN_EN] = pullup_en_r;
            default:               rdata = 8'h00;
        endcase
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r          <= 1'b0;
            avs_readdata_o <= 32'h00000000;
        end else begin
            ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
            if (avs_read_i & ~ack_r)
                avs_readdata_o <= {24'h000000, rdata};
        end
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dir_a_r <= `RESET_DIRECTION; dir_b_r <= `RESET_DIRECTION;
            dir_c_r <= `RESET_DIRECTION; dir_d_r <= `RESET_DIRECTION;
            dir_f_r <= `RESET_DIRECTION; dir_g_r <= `RESET_DIRECTION;
            lat_a_r <= `RESET_LATCH; lat_b_r <= `RESET_LATCH;
            lat_c_r <= `RESET_LATCH; lat_d_r <= `RESET_LATCH;
            lat_f_r <= `RESET_LATCH; lat_g_r <= `RESET_LATCH;
            c_open_drain_r  <= 1'b0;
            read_vis_r      <= 1'b0;
            read_vis_done_r <= 1'b0;
            pullup_r        <= 3'b000;
            pullup_en_r     <= 1'b0;
        end else if (wr & ~ack_r) begin
            case (idx)
                `REG_PORT_A_DATA:      lat_a_r <= avs_writedata_i[7:0];
                `REG_PORT_B_DATA:      lat_b_r <= avs_writedata_i[7:0];
                `REG_PORT_C_DATA:      lat_c_r <= avs_writedata_i[7:0];
                `REG_PORT_D_DATA:      lat_d_r <= avs_writedata_i[7:0]
                                                  & `PORT_D_MASK;
                `REG_PORT_F_DATA:      lat_f_r <= avs_writedata_i[7:0];
                `REG_PORT_G_DATA:      lat_g_r <= avs_writedata_i[7:0];
                `REG_PORT_A_DIRECTION: dir_a_r <= avs_writedata_i[7:0];
                `REG_PORT_B_DIRECTION: dir_b_r <= avs_writedata_i[7:0];
                `REG_PORT_C_DIRECTION: dir_c_r <= avs_writedata_i[7:0];
                `REG_PORT_D_DIRECTION: dir_d_r <= avs_writedata_i[7:0]
                                                  & `PORT_D_MASK;
                `REG_PORT_F_DIRECTION: dir_f_r <= avs_writedata_i[7:0];
                `REG_PORT_G_DIRECTION: dir_g_r <= avs_writedata_i[7:0];
                `REG_SYSTEM_OPTIONS_TWO: begin
                    c_open_drain_r <=
                        avs_writedata_i[`SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN];
                    if (!read_vis_done_r) begin
                        read_vis_r <=
                            avs_writedata_i[`SYSTEM_OPTIONS_TWO_READ_VIS_ECLK_OFF];
                        read_vis_done_r <= 1'b1;
                    end
                end
                `REG_PULLUP_ASSIGNMENT: pullup_r <= avs_writedata_i[2:0];
                `REG_SYSTEM_CONFIG:
                    pullup_en_r <= avs_writedata_i[`CFG_PULLUP_ASSIGN_EN];
                default: ;
            endcase
        end
    end

endmodule

// ---- design/multi_port_parallel_io_defs.vh ----
`ifndef MULTI_PORT_PARALLEL_IO_DEFS_VH
`define MULTI_PORT_PARALLEL_IO_DEFS_VH
// Register indices; the byte address is four times the index.
`define REG_PORT_A_DATA      7'h00
`define REG_PORT_F_DIRECTION 7'h03
`define REG_PORT_B_DATA      7'h04
`define REG_PORT_C_DATA      7'h05
`define REG_PORT_C_DIRECTION 7'h07
`define REG_PORT_D_DATA      7'h08
`define REG_PORT_D_DIRECTION 7'h09
`define REG_PORT_E_DATA      7'h0a
`define REG_PORT_A_DIRECTION 7'h01
`define REG_PORT_B_DIRECTION 7'h06
`define REG_PORT_F_DATA      7'h0b
`define REG_SYSTEM_OPTIONS_TWO 7'h38
`define REG_SYSTEM_CONFIG    7'h3f
`define REG_PULLUP_ASSIGNMENT 7'h2c
`define REG_PORT_G_DATA      7'h7e
`define REG_PORT_G_DIRECTION 7'h7f
// Field positions.
`define SYSTEM_OPTIONS_TWO_PORT_C_OPEN_DRAIN 5
`define SYSTEM_OPTIONS_TWO_READ_VIS_ECLK_OFF 4
`define CFG_PULLUP_ASSIGN_EN   0
`define PULLUP_ASSIGNMENT_G 2
`define PULLUP_ASSIGNMENT_F 1
`define PULLUP_ASSIGNMENT_B 0
// Reset values.
`define RESET_DIRECTION 8'h00
`define RESET_LATCH     8'h00
`define RESET_SYSTEM_OPTIONS_TWO      8'h00
`define PORT_D_MASK     8'h3f
`endif

// ---- verification/pin_model.sv ----
`timescale 1ns/1ps
module pin_model #(
    parameter int W = 48
) (
    input  logic [W-1:0] out_i,
    input  logic [W-1:0] oe_n_i,
    input  logic [W-1:0] ext_i,
    output logic [W-1:0] pin_o
);
    // The far side drives every released line, so a line that no one
    // drives never shows a stale value; ext_i all ones acts as a pull-up.
    // board pull-up
    assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// ---- verification/multi_port_parallel_io_props.sv ----
`timescale 1ns/1ps
module mppio_props (
    input logic        clk_sys_i,
    input logic        rst_i,
    input logic        avs_read_i,
    input logic        avs_write_i,
    input logic        avs_waitrequest_o,
    input logic [31:0] avs_readdata_o,
    input logic        expanded_mode_i,
    input logic        eclk_i,
    input logic        eclk_pin_o,
    input logic [15:0] ext_addr_i,
    input logic        ext_rw_i,
    input logic [7:0]  timer_en_i,
    input logic [7:0]  timer_oe_i,
    input logic [7:0]  port_a_oe_n_o,
    input logic [7:0]  port_b_out_o,
    input logic [7:0]  port_f_out_o,
    input logic [7:0]  port_g_out_o,
    input logic [7:0]  port_g_oe_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wait_state_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o) else $error("no answer after one wait");
    read_high_zero_a: assert property (
        avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    eclk_gate_a: assert property (
        eclk_pin_o |-> eclk_i) else $error("e pin high without e clock");
    high_addr_a: assert property (
        expanded_mode_i |-> port_b_out_o == ext_addr_i[15:8])
        else $error("port b not high address");
    low_addr_a: assert property (
        expanded_mode_i |-> port_f_out_o == ext_addr_i[7:0])
        else $error("port f not low address");
    rw_line_a: assert property (
        expanded_mode_i |-> !port_g_oe_n_o[7] && port_g_out_o[7] == ext_rw_i)
        else $error("pin seven not read write line");
    timer_own_a: assert property (
        ((port_a_oe_n_o ^ ~timer_oe_i) & timer_en_i) == 8'h00)
        else $error("timer does not own its pins");
    reset_input_a: assert property (
        $fell(rst_i) && !expanded_mode_i && timer_en_i == 8'h00 |->
        &port_a_oe_n_o && &port_g_oe_n_o) else $error("pin driven after reset");
endmodule
bind multi_port_parallel_io mppio_props u_props (.*);

// ---- verification/tb_multi_port_parallel_io.sv ----
`timescale 1ns/1ps
module tb_multi_port_parallel_io;
    logic        clk_sys_i, rst_i, avs_read_i, avs_write_i, eclk_i;
    logic        avs_waitrequest_o, expanded_mode_i, eclk_pin_o, ext_rw_i;
    logic        ext_data_drive_i, int_read_i;
    logic [8:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0]  avs_byteenable_i;
    logic [15:0] ext_addr_i;
    logic [7:0]  ext_data_out_i, int_read_data_i, timer_en_i, timer_out_i;
    logic [7:0]  timer_oe_i, port_a_in_i, port_a_out_o, port_a_oe_n_o;
    logic [7:0]  port_b_in_i, port_b_out_o, port_b_oe_n_o, port_c_in_i;
    logic [7:0]  port_c_out_o, port_c_oe_n_o, port_c_data_o, port_e_in_i;
    logic [7:0]  port_f_in_i, port_f_out_o, port_f_oe_n_o, port_g_in_i;
    logic [7:0]  port_g_out_o, port_g_oe_n_o, r, d, l, e, m;
    logic [5:0]  exp_addr_i, serial_en_i, serial_out_i, serial_oe_i;
    logic [5:0]  port_d_in_i, port_d_out_o, port_d_oe_n_o;
    logic [2:0]  pullup_en_o;
    logic [1:0]  pad_d;
    logic [47:0] pout, poe_n, ext, pin;
    int          num_errors = 0;
    int          n_checks = 0;
    int          p;
    localparam logic [41:0] dat_idx = {7'h7e, 7'h0b, 7'h08, 7'h05, 7'h04, 7'h00};
    localparam logic [41:0] dir_idx = {7'h7f, 7'h03, 7'h09, 7'h07, 7'h06, 7'h01};
    assign pout = {port_g_out_o, port_f_out_o, 2'b00, port_d_out_o,
                   port_c_out_o, port_b_out_o, port_a_out_o};
    assign poe_n = {port_g_oe_n_o, port_f_oe_n_o, 2'b11, port_d_oe_n_o,
                    port_c_oe_n_o, port_b_oe_n_o, port_a_oe_n_o};
    assign {port_g_in_i, port_f_in_i, pad_d, port_d_in_i, port_c_in_i,
            port_b_in_i, port_a_in_i} = pin;
    multi_port_parallel_io u_dut (.*);
    pin_model u_far (.out_i(pout), .oe_n_i(poe_n), .ext_i(ext), .pin_o(pin));
    initial begin
        clk_sys_i = 0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        eclk_i <= 1'($urandom);
        {ext_addr_i, ext_rw_i, exp_addr_i} <= 23'($urandom);
        {timer_out_i, timer_oe_i, serial_out_i, serial_oe_i} <= 28'($urandom);
        {ext_data_out_i, int_read_data_i} <= 16'($urandom);
    end
    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] y);
        n_checks++;
        if (y !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] w);
        int n;
        n = 0;
        avs_address_i <= {a, 2'b00};
        avs_writedata_i <= {24'h0, w};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n == 50) begin
            num_errors++;
            final_report();
        end
        r = avs_readdata_o[7:0];
        avs_write_i <= 0;
        avs_read_i <= 0;
        @(posedge clk_sys_i);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #60us;
        num_errors++;
        final_report();
    end
    initial begin
        void'($urandom(48));
        {avs_read_i, avs_write_i, ext_data_drive_i, int_read_i} = 4'h0;
        {avs_address_i, avs_writedata_i, ext, timer_en_i, serial_en_i} = 0;
        {eclk_i, ext_addr_i, ext_rw_i, exp_addr_i, port_e_in_i} = 0;
        {timer_out_i, timer_oe_i, serial_out_i, serial_oe_i} = 0;
        {ext_data_out_i, int_read_data_i, expanded_mode_i} = 0;
        avs_byteenable_i = 4'h1;
        rst_i = 1;
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 0;
        @(posedge clk_sys_i);
        for (p = 0; p < 6; p++) begin
            bus(0, dir_idx[7*p+:7], 8'h00);
            chk("direction reset", 8'h00, r);
        end
        bus(1, 7'h01, 8'hff);
        chk("unwritten latch", 8'h00, port_a_out_o);
        $display("test reset done");
        for (int k = 0; k < 24; k++) begin
            p = k % 6;
            {d, l, e} = 24'($urandom);
            m = (p == 3) ? 8'h3f : 8'hff;
            ext[8*p+:8] <= e;
            bus(1, dat_idx[7*p+:7], l);
            bus(1, dir_idx[7*p+:7], d);
            chk("enable", ~(d & m), poe_n[8*p+:8]);
            chk("latch drive", l & d & m, pout[8*p+:8] & d & m);
            bus(0, dat_idx[7*p+:7], 8'h00);
            chk("pin read", ((l & d) | (e & ~d)) & m, r & m);
            bus(0, dir_idx[7*p+:7], 8'h00);
            chk("direction", d & m, r);
        end
        $display("test gpio done");
        bus(1, 7'h00, 8'h5a);
        bus(1, 7'h01, 8'hff);
        timer_en_i <= 8'h0f;
        serial_en_i <= 6'h3f;
        @(negedge clk_sys_i);
        chk("timer", timer_out_i & timer_oe_i & 8'h0f,
            port_a_out_o & timer_oe_i & 8'h0f);
        chk("serial", {2'b00, serial_out_i & serial_oe_i},
            {2'b00, port_d_out_o & serial_oe_i});
        @(posedge clk_sys_i);
        timer_en_i <= 8'h00;
        serial_en_i <= 6'h00;
        @(negedge clk_sys_i);
        chk("released", 8'h5a, port_a_out_o);
        @(posedge clk_sys_i);
        port_e_in_i <= 8'(($urandom));
        repeat (3) @(posedge clk_sys_i);
        // No conversion runs here, so the input port may be read.
        bus(0, 7'h0a, 8'h00);
        chk("input port", port_e_in_i, r);
        $display("test function done");
        bus(1, 7'h38, 8'h10);
        chk("e pin low", 8'h00, {7'h0, eclk_pin_o});
        bus(1, 7'h38, 8'h20);
        bus(0, 7'h38, 8'h00);
        chk("one write", 8'h30, r);
        l = 8'(($urandom));
        // Far side holds released port C lines low, so a pin read differs.
        ext[23:16] <= 8'h00;
        bus(1, 7'h05, l);
        bus(1, 7'h07, 8'hff);
        chk("open drain", l, port_c_oe_n_o);
        bus(0, 7'h05, 8'h00);
        chk("driver read", l, r);
        bus(1, 7'h2c, 8'h07);
        chk("pullup gated", 8'h00, {5'h0, pullup_en_o});
        bus(1, 7'h3f, 8'h01);
        chk("pullup on", 8'h07, {5'h0, pullup_en_o});
        bus(1, 7'h10, 8'h77);
        bus(0, 7'h10, 8'h00);
        chk("unmapped", 8'h00, r);
        bus(1, 7'h03, 8'h3c);
        avs_byteenable_i <= 4'h0;
        bus(1, 7'h03, 8'h99);
        avs_byteenable_i <= 4'h1;
        bus(0, 7'h03, 8'h00);
        chk("lane off", 8'h3c, r);
        $display("test options done");
        rst_i <= 1;
        expanded_mode_i <= 1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 0;
        @(posedge clk_sys_i);
        chk("expanded inputs", 8'hff, port_a_oe_n_o);
        bus(1, 7'h38, 8'h10);
        int_read_i <= 1;
        @(negedge clk_sys_i);
        chk("visibility", int_read_data_i, port_c_out_o);
        chk("exp address", {2'b00, exp_addr_i},
            {2'b00, port_g_out_o[5:0]});
        @(posedge clk_sys_i);
        int_read_i <= 0;
        ext_data_drive_i <= 1;
        @(negedge clk_sys_i);
        chk("data bus", ext_data_out_i, port_c_out_o);
        repeat (100) @(posedge clk_sys_i);
        $display("test expanded done");
        final_report();
    end
endmodule
